// ### design/cfm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfm_params.svh"

module cfm_monitor
#(
  parameter int XO_PER_MS = `CFM_XO_PER_MS
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`CFM_NIN-1:0] in_clk_i,
  input wire logic xo_clk_i,
  input wire logic [`CFM_NIN-1:0] pll_ref_i,
  input wire logic [`CFM_NIN-1:0] pll_fb_i,
  output logic [`CFM_NIN-1:0] input_loss_flag_o,
  output logic [`CFM_NIN-1:0] drift_flag_o,
  output logic [`CFM_NIN-1:0] lock_fail_flag_o,
  output logic ref_osc_loss_flag_o,
  output logic interrupt_out_n_o,
  output logic [1:0] gpo_o,
  output logic [`CFM_NIN-1:0] switch_req_o
);
  import cfm_pkg::*;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  function automatic logic [16:0] val_ms(input logic [2:0] sel);
    case (sel)
      3'h0: val_ms = 17'h00002;
      3'h1: val_ms = 17'h00080;
      3'h2: val_ms = 17'h00100;
      3'h3: val_ms = 17'h003e8;
      3'h4: val_ms = 17'h00fa0;
      3'h5: val_ms = 17'h07d00;
      3'h6: val_ms = 17'h0fa00;
      default: val_ms = 17'h1f400;
    endcase
  endfunction

  // Lock thresholds in units of 0.05 ppb.
  function automatic logic [63:0] lock_thr(input logic [3:0] code);
    case (code)
      4'h0: lock_thr = 64'h1;
      4'h1: lock_thr = 64'h2;
      4'h2: lock_thr = 64'ha;
      4'h3: lock_thr = 64'h14;
      4'h4: lock_thr = 64'hfa0;
      4'h5: lock_thr = 64'h1f40;
      4'h6: lock_thr = 64'h9c40;
      4'h7: lock_thr = 64'h13880;
      4'h8: lock_thr = 64'h61a80;
      4'h9: lock_thr = 64'hc3500;
      4'ha: lock_thr = 64'h3d0900;
      4'hb: lock_thr = 64'h7a1200;
      4'hc: lock_thr = 64'h2625a00;
      default: lock_thr = 64'h4c4b400;
    endcase
  endfunction

  function automatic logic [20:0] abs_diff(input logic [20:0] a, input logic [20:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // True when diff/base exceeds thr/scale, without a divider.
  function automatic logic ratio_over(input logic [20:0] diff, input logic [20:0] base,
                                      input logic [63:0] scale, input logic [63:0] thr);
    ratio_over = (64'(diff) * scale) > (thr * 64'(base));
  endfunction

  // Set wins; a clean run of the selected time drops the flag; a violation restarts it.
  function automatic logic [17:0] val_step(input logic flag, input logic set_v, input logic viol,
                                           input logic [16:0] tmr, input logic [16:0] lim,
                                           input logic tick);
    val_step = {flag, tmr};
    if (set_v)
    begin
      val_step = {1'b1, 17'h0};
    end
    else if (!flag || viol)
    begin
      val_step = {flag, 17'h0};
    end
    else if (tick)
    begin
      if (tmr + 17'h1 >= lim)
      begin
        val_step = {1'b0, 17'h0};
      end
      else
      begin
        val_step = {1'b1, tmr + 17'h1};
      end
    end
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  cfm_state_s s_r;
  cfm_state_s s_nxt;
  logic [`CFM_NPIN-1:0] rise;
  logic [`CFM_NIN-1:0] dedge;
  logic [`CFM_NMON-1:0] set_v;
  logic [`CFM_NMON-1:0] viol_v;
  logic [`CFM_NEV-1:0] ev;
  logic [`CFM_NEV-1:0] clr_w;
  logic [3:0][16:0] lim;
  logic ms_tick;
  logic gedge;
  logic weval;
  logic bus_req;
  logic [17:0] vs;
  logic [20:0] c;
  logic [20:0] a;
  logic [20:0] r1;
  logic [20:0] fbn;
  logic [20:0] fw;
  logic [63:0] cthr_s;
  logic [63:0] cthr_c;

  assign ev = {s_r.xo_loss, s_r.flag};
  assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    s_nxt = s_r;
    rise = s_r.s2 & ~s_r.s3;
    s_nxt.s1 = {pll_fb_i, pll_ref_i, xo_clk_i, in_clk_i};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    dedge = '0;
    set_v = '0;
    viol_v = '0;
    ms_tick = 1'b0;
    weval = 1'b0;
    c = '0;
    a = '0;
    r1 = '0;
    clr_w = '0;
    vs = '0;
    cthr_s = `CFM_COARSE_STEP * 64'(s_r.fd_cfg.cset + 5'h1);
    cthr_c = `CFM_COARSE_STEP * 64'(s_r.fd_cfg.cclr + 5'h1);
    fw = 21'({s_r.win, 4'h0});
    fbn = '0;

    // Oscillator presence and the millisecond tick that drives all timers.
    if (rise[`CFM_PIN_XO])
    begin
      s_nxt.xo_gap = '0;
      if (s_r.xo_pre >= 16'(XO_PER_MS - 1))
      begin
        s_nxt.xo_pre = '0;
        ms_tick = 1'b1;
      end
      else
      begin
        s_nxt.xo_pre = s_r.xo_pre + 16'h1;
      end
    end
    else if (s_r.xo_gap != `CFM_XO_LOSS_CYC)
    begin
      s_nxt.xo_gap = s_r.xo_gap + 8'h1;
    end
    s_nxt.xo_loss = (s_r.xo_gap == `CFM_XO_LOSS_CYC);

    // Predivided inputs and missing-edge counting.
    for (int i = 0; i < `CFM_NIN; i++)
    begin
      if (rise[i])
      begin
        if (s_r.pdiv[i] >= s_r.prediv[i])
        begin
          s_nxt.pdiv[i] = '0;
          dedge[i] = 1'b1;
        end
        else
        begin
          s_nxt.pdiv[i] = s_r.pdiv[i] + 8'h1;
        end
      end
      if (dedge[i])
      begin
        s_nxt.gap[i] = '0;
        s_nxt.missed[i] = '0;
      end
      else if (s_r.gap[i] + 16'h1 >= s_r.period)
      begin
        s_nxt.gap[i] = '0;
        if (s_r.missed[i] != 8'hff)
        begin
          s_nxt.missed[i] = s_r.missed[i] + 8'h1;
        end
      end
      else
      begin
        s_nxt.gap[i] = s_r.gap[i] + 16'h1;
      end
      set_v[i] = s_r.missed[i] >= s_r.loss_cfg.trig;
      viol_v[i] = s_r.missed[i] >= s_r.loss_cfg.clr;
    end

    // Golden reference window for drift.
    gedge = (s_r.ctrl.gold >= `CFM_GOLD_XO) ? rise[`CFM_PIN_XO] : dedge[s_r.ctrl.gold[1:0]];
    if (gedge)
    begin
      if (s_r.gold_cnt + 16'h1 >= s_r.win)
      begin
        s_nxt.gold_cnt = '0;
        weval = 1'b1;
      end
      else
      begin
        s_nxt.gold_cnt = s_r.gold_cnt + 16'h1;
      end
    end
    if (weval)
    begin
      s_nxt.sub = s_r.sub + 4'h1;
    end
    for (int i = 0; i < `CFM_NIN; i++)
    begin
      // An edge in the closing cycle belongs to the window that closes.
      c = 21'(s_r.cnt[i]) + 21'(dedge[i]);
      a = s_r.acc[i] + c;
      if (weval)
      begin
        s_nxt.cnt[i] = '0;
        set_v[8 + i] = ratio_over(abs_diff(c, 21'(s_r.win)), 21'(s_r.win), `CFM_PPM_SCALE, cthr_s);
        viol_v[8 + i] = ratio_over(abs_diff(c, 21'(s_r.win)), 21'(s_r.win), `CFM_PPM_SCALE, cthr_c);
        if (s_r.sub == `CFM_SUBWIN)
        begin
          s_nxt.acc[i] = '0;
          set_v[4 + i] = ratio_over(abs_diff(a, fw), fw, `CFM_PPM_SCALE,
                                    `CFM_FINE_STEP * 64'(s_r.fd_cfg.fset));
          viol_v[4 + i] = ratio_over(abs_diff(a, fw), fw, `CFM_PPM_SCALE,
                                     `CFM_FINE_STEP * 64'(s_r.fd_cfg.fclr));
        end
        else
        begin
          s_nxt.acc[i] = a;
        end
      end
      else
      begin
        s_nxt.cnt[i] = s_r.cnt[i] + {16'h0, dedge[i]};
      end
    end

    // Lock monitors compare feedback and reference edges per PLL.
    for (int p = 0; p < `CFM_NIN; p++)
    begin
      r1 = 21'(s_r.lref[p]) + 21'h1;
      fbn = 21'(s_r.lfb[p]) + 21'(rise[`CFM_PIN_FB + p]);
      if (rise[`CFM_PIN_FB + p])
      begin
        s_nxt.lfb[p] = s_r.lfb[p] + 16'h1;
      end
      if (rise[`CFM_PIN_REF + p])
      begin
        if (r1 >= 21'(s_r.ll_cfg.win))
        begin
          s_nxt.lref[p] = '0;
          s_nxt.lfb[p] = '0;
          set_v[12 + p] = ratio_over(abs_diff(r1, fbn), r1, `CFM_PPB20_SCALE,
                                     lock_thr(s_r.ll_cfg.set));
          viol_v[12 + p] = ratio_over(abs_diff(r1, fbn), r1, `CFM_PPB20_SCALE,
                                      lock_thr(s_r.ll_cfg.clr));
        end
        else
        begin
          s_nxt.lref[p] = r1[15:0];
        end
      end
    end

    // Validated flags: loss, fine, coarse, lock.
    lim[0] = val_ms(s_r.loss_cfg.val);
    lim[1] = val_ms(s_r.fd_cfg.fval);
    lim[2] = val_ms(s_r.fd_cfg.cval);
    lim[3] = val_ms(s_r.ll_cfg.dly);
    for (int m = 0; m < `CFM_NMON; m++)
    begin
      vs = val_step(s_r.flag[m], set_v[m], viol_v[m], s_r.tmr[m], lim[m / 4], ms_tick);
      s_nxt.flag[m] = vs[17];
      s_nxt.tmr[m] = vs[16:0];
    end

    // Register bus.
    s_nxt.ack = bus_req;
    if (bus_req && wb_we_i && wb_adr_i == `CFM_OFF_NOTIFY)
    begin
      clr_w = `CFM_NEV'(wmask(32'h0, wb_dat_i, wb_sel_i));
    end
    s_nxt.notify = (s_r.notify & ~clr_w) | (ev & s_r.nen);
    if (bus_req && wb_we_i)
    begin
      case (wb_adr_i)
        `CFM_OFF_CTRL: s_nxt.ctrl = wmask(s_r.ctrl, wb_dat_i, wb_sel_i);
        `CFM_OFF_PREDIV: s_nxt.prediv = wmask(s_r.prediv, wb_dat_i, wb_sel_i);
        `CFM_OFF_LOSS: s_nxt.loss_cfg = 19'(wmask(32'(s_r.loss_cfg), wb_dat_i, wb_sel_i));
        `CFM_OFF_PERIOD: s_nxt.period = 16'(wmask(32'(s_r.period), wb_dat_i, wb_sel_i));
        `CFM_OFF_FD: s_nxt.fd_cfg = wmask(s_r.fd_cfg, wb_dat_i, wb_sel_i);
        `CFM_OFF_WIN: s_nxt.win = 16'(wmask(32'(s_r.win), wb_dat_i, wb_sel_i));
        `CFM_OFF_LL: s_nxt.ll_cfg = wmask(s_r.ll_cfg, wb_dat_i, wb_sel_i);
        `CFM_OFF_NEN: s_nxt.nen = `CFM_NEV'(wmask(32'(s_r.nen), wb_dat_i, wb_sel_i));
        `CFM_OFF_IMASK: s_nxt.imask = `CFM_NEV'(wmask(32'(s_r.imask), wb_dat_i, wb_sel_i));
        `CFM_OFF_GPO0: s_nxt.gpo_cfg[0] = wmask(s_r.gpo_cfg[0], wb_dat_i, wb_sel_i);
        `CFM_OFF_GPO1: s_nxt.gpo_cfg[1] = wmask(s_r.gpo_cfg[1], wb_dat_i, wb_sel_i);
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    end
    s_nxt.rdat = '0;
    if (bus_req && !wb_we_i)
    begin
      case (wb_adr_i)
        `CFM_OFF_CTRL: s_nxt.rdat = {27'h0, s_r.ctrl.sw_coarse, s_r.ctrl.sw_fine, s_r.ctrl.gold};
        `CFM_OFF_PREDIV: s_nxt.rdat = s_r.prediv;
        `CFM_OFF_LOSS: s_nxt.rdat = 32'(s_r.loss_cfg);
        `CFM_OFF_PERIOD: s_nxt.rdat = 32'(s_r.period);
        `CFM_OFF_FD: s_nxt.rdat = {2'h0, s_r.fd_cfg[29:0]};
        `CFM_OFF_WIN: s_nxt.rdat = 32'(s_r.win);
        `CFM_OFF_LL: s_nxt.rdat = {s_r.ll_cfg.win, 5'h0, s_r.ll_cfg[10:0]};
        `CFM_OFF_STATUS: s_nxt.rdat = 32'(ev);
        `CFM_OFF_NOTIFY: s_nxt.rdat = 32'(s_r.notify);
        `CFM_OFF_NEN: s_nxt.rdat = 32'(s_r.nen);
        `CFM_OFF_IMASK: s_nxt.rdat = 32'(s_r.imask);
        `CFM_OFF_GPO0: s_nxt.rdat = {s_r.gpo_cfg[0].or_mode, 9'h0, s_r.gpo_cfg[0][21:0]};
        `CFM_OFF_GPO1: s_nxt.rdat = {s_r.gpo_cfg[1].or_mode, 9'h0, s_r.gpo_cfg[1][21:0]};
        default: s_nxt.rdat = '0;
      endcase
    end

    // Pins driven from the notify bits (interrupt, GPO) and the flags (switch).
    s_nxt.irq_n = !(|(s_r.notify & s_r.imask));
    for (int g = 0; g < 2; g++)
    begin
      s_nxt.gpo[g] = s_r.gpo_cfg[g].or_mode ? |(s_r.notify & s_r.gpo_cfg[g].mask)
                   : (s_r.gpo_cfg[g].sel < 5'(`CFM_NEV)) && s_r.notify[s_r.gpo_cfg[g].sel];
    end
    for (int i = 0; i < `CFM_NIN; i++)
    begin
      s_nxt.sw[i] = s_r.flag[i] | (s_r.ctrl.sw_fine & s_r.flag[4 + i])
                  | (s_r.ctrl.sw_coarse & s_r.flag[8 + i]);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '0;
      s_r.loss_cfg <= `CFM_RST_LOSS;
      s_r.period <= `CFM_RST_PERIOD;
      s_r.fd_cfg <= `CFM_RST_FD;
      s_r.win <= `CFM_RST_WIN;
      s_r.ll_cfg <= `CFM_RST_LL;
      s_r.irq_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign wb_dat_o = s_r.rdat;
  assign wb_ack_o = s_r.ack;
  assign input_loss_flag_o = s_r.flag[3:0];
  assign drift_flag_o = s_r.flag[7:4] | s_r.flag[11:8];
  assign lock_fail_flag_o = s_r.flag[15:12];
  assign ref_osc_loss_flag_o = s_r.xo_loss;
  assign interrupt_out_n_o = s_r.irq_n;
  assign gpo_o = s_r.gpo;
  assign switch_req_o = s_r.sw;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  status_read_a: assert property (bus_req && !wb_we_i && wb_adr_i == `CFM_OFF_STATUS |=> wb_ack_o && wb_dat_o == 32'($past(ev))) else $error("status read wrong");
  notify_hold_a: assert property (!(bus_req && wb_we_i && wb_adr_i == `CFM_OFF_NOTIFY) |=> (($past(s_r.notify) & ~s_r.notify) == '0)) else $error("notify dropped");
  notify_en_a: assert property (##1 ((s_r.notify & ~$past(s_r.notify) & ~$past(s_r.nen)) == '0)) else $error("disabled notify set");
  gpo_or_a: assert property (s_r.gpo_cfg[0].or_mode |=> gpo_o[0] == |($past(s_r.notify) & $past(s_r.gpo_cfg[0].mask))) else $error("gpo mismatch");
  irq_pin_a: assert property (|(s_r.notify & s_r.imask) |=> !interrupt_out_n_o) else $error("irq missing");
  loss_set_a: assert property (s_r.missed[0] >= s_r.loss_cfg.trig |=> input_loss_flag_o[0]) else $error("loss not set");
  set_wins_a: assert property (ev[0] && s_r.nen[0] |=> s_r.notify[0]) else $error("clear beat event");
  xo_loss_a: assert property (s_r.xo_gap == `CFM_XO_LOSS_CYC |=> ref_osc_loss_flag_o) else $error("osc loss missed");
  switch_a: assert property (input_loss_flag_o[0] |=> switch_req_o[0]) else $error("switch missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");

  loss_cov_c: cover property (input_loss_flag_o[0] ##1 !input_loss_flag_o[0]);
  drift_cov_c: cover property (drift_flag_o[1]);
  lock_cov_c: cover property (lock_fail_flag_o[0]);
  irq_cov_c: cover property (!interrupt_out_n_o);

endmodule
`default_nettype wire

// ### design/cfm_params.svh
// Function
// - Live status bit high only during defect.
// - Sticky notify sets, holds until software clears.
// - Each notify bit individually enabled by software.
// - Outputs show one notify or ORed set.
// - Selected notify bits drive the interrupt pin.
// - Four defect kinds: loss, drift, lock, oscillator.
// - Input monitors run after the input predivider.
// - Loss asserts after trigger count missing edges.
// - Recovered when missing edges below clear count.
// - Loss clears after selectable clean validation time.
// - Drift measured against one selectable golden reference.
// - Fine thresholds 2 ppm steps, 2 to 510; the code gives 0 to 510, with 0 ppm at fset 0.
// - Fine drift asserts above fine set threshold.
// - Fine drift clears below clear threshold after timer.
// - Fine validation time selectable, violations restart it.
// - Coarse thresholds 100 ppm steps, 100 to 1600.
// - Coarse drift asserts above coarse set threshold.
// - Coarse drift clears after clean validation time.
// - Drift optionally ORed with loss for switching.
// - Lock fault when feedback and reference frequencies differ.
// - Oscillator loss flagged when reference clock absent.
// - Lock fault held for delay after settling.
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH

`define CFM_NIN 4
`define CFM_NEV 17
`define CFM_NMON 16
`define CFM_NPIN 13

`define CFM_OFF_CTRL 8'h00
`define CFM_OFF_PREDIV 8'h04
`define CFM_OFF_LOSS 8'h08
`define CFM_OFF_PERIOD 8'h0c
`define CFM_OFF_FD 8'h10
`define CFM_OFF_WIN 8'h14
`define CFM_OFF_LL 8'h18
`define CFM_OFF_STATUS 8'h1c
`define CFM_OFF_NOTIFY 8'h20
`define CFM_OFF_NEN 8'h24
`define CFM_OFF_IMASK 8'h28
`define CFM_OFF_GPO0 8'h2c
`define CFM_OFF_GPO1 8'h30

`define CFM_PIN_XO 4
`define CFM_PIN_REF 5
`define CFM_PIN_FB 9
`define CFM_GOLD_XO 3'h4

`define CFM_RST_LOSS 19'h00204
`define CFM_RST_PERIOD 16'h0010
`define CFM_RST_FD 32'h0012050a
`define CFM_RST_WIN 16'h0400
`define CFM_RST_LL 32'h04000067

`define CFM_CLK_MHZ 125
`define CFM_XO_LOSS_NS 512
`define CFM_XO_LOSS_CYC 8'(`CFM_XO_LOSS_NS * `CFM_CLK_MHZ / 1000)
`define CFM_XO_PER_MS 25000
`define CFM_SUBWIN 4'hf
`define CFM_PPM_SCALE 64'hf4240
`define CFM_PPB20_SCALE 64'h4a817c800
`define CFM_FINE_STEP 64'h2
`define CFM_COARSE_STEP 64'h64

`endif

// ### design/cfm_pkg.sv
`include "cfm_params.svh"

package cfm_pkg;

  typedef struct packed {
    logic [26:0] pad;
    logic sw_coarse;
    logic sw_fine;
    logic [2:0] gold;
  } cfm_ctrl_s;

  typedef struct packed {
    logic [2:0] val;
    logic [7:0] clr;
    logic [7:0] trig;
  } cfm_loss_cfg_s;

  typedef struct packed {
    logic [1:0] pad;
    logic [2:0] cval;
    logic [2:0] fval;
    logic [3:0] cclr;
    logic [3:0] cset;
    logic [7:0] fclr;
    logic [7:0] fset;
  } cfm_fd_cfg_s;

  typedef struct packed {
    logic [15:0] win;
    logic [4:0] pad;
    logic [2:0] dly;
    logic [3:0] clr;
    logic [3:0] set;
  } cfm_ll_cfg_s;

  typedef struct packed {
    logic or_mode;
    logic [8:0] pad;
    logic [4:0] sel;
    logic [`CFM_NEV-1:0] mask;
  } cfm_gpo_cfg_s;

  typedef struct packed {
    logic [`CFM_NPIN-1:0] s1;
    logic [`CFM_NPIN-1:0] s2;
    logic [`CFM_NPIN-1:0] s3;
    logic [`CFM_NIN-1:0][7:0] pdiv;
    logic [`CFM_NIN-1:0][15:0] gap;
    logic [`CFM_NIN-1:0][7:0] missed;
    logic [15:0] gold_cnt;
    logic [3:0] sub;
    logic [`CFM_NIN-1:0][16:0] cnt;
    logic [`CFM_NIN-1:0][20:0] acc;
    logic [`CFM_NIN-1:0][15:0] lref;
    logic [`CFM_NIN-1:0][15:0] lfb;
    logic [7:0] xo_gap;
    logic [15:0] xo_pre;
    logic xo_loss;
    logic [`CFM_NMON-1:0] flag;
    logic [`CFM_NMON-1:0][16:0] tmr;
    cfm_ctrl_s ctrl;
    logic [`CFM_NIN-1:0][7:0] prediv;
    cfm_loss_cfg_s loss_cfg;
    logic [15:0] period;
    cfm_fd_cfg_s fd_cfg;
    logic [15:0] win;
    cfm_ll_cfg_s ll_cfg;
    logic [`CFM_NEV-1:0] notify;
    logic [`CFM_NEV-1:0] nen;
    logic [`CFM_NEV-1:0] imask;
    cfm_gpo_cfg_s [1:0] gpo_cfg;
    logic ack;
    logic [31:0] rdat;
    logic [1:0] gpo;
    logic irq_n;
    logic [`CFM_NIN-1:0] sw;
  } cfm_state_s;

endpackage

// ### tb/cfm_clk_src.sv
`timescale 1ns/10ps
`default_nettype none

// Reference clocks at the far side; a stopped clock stands still at low.
module cfm_clk_src
(
  input wire logic [3:0] in_run_i,
  input wire logic xo_run_i,
  input wire logic [3:0] ref_run_i,
  input wire logic [3:0] fb_run_i,
  output logic [3:0] in_clk_o,
  output logic xo_clk_o,
  output logic [3:0] pll_ref_o,
  output logic [3:0] pll_fb_o
);
  logic ph;

  initial ph = 1'b0;
  // Half period of 8 core cycles keeps every edge countable after the sync.
  always #64 ph = ~ph;
  assign in_clk_o = in_run_i & {4{ph}};
  assign xo_clk_o = xo_run_i & ph;
  assign pll_ref_o = ref_run_i & {4{ph}};
  assign pll_fb_o = fb_run_i & {4{ph}};
endmodule

`default_nettype wire

// ### tb/clock_fault_monitor_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "cfm_params.svh"

module clock_fault_monitor_test;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] in_run = 4'hf;
  logic xo_run = 1'b1;
  logic [3:0] ref_run = 4'hf;
  logic [3:0] fb_run = 4'hf;
  logic [3:0] in_clk, pll_ref, pll_fb, loss, drift, lock, swr;
  logic xo_clk, osc, int_n;
  logic [1:0] gpo;
  logic [31:0] rv;
  int num_errors = 0;
  int checked = 0;

  always #4 core_clk_i = ~core_clk_i;

  cfm_clk_src src (.in_run_i(in_run), .xo_run_i(xo_run), .ref_run_i(ref_run), .fb_run_i(fb_run),
    .in_clk_o(in_clk), .xo_clk_o(xo_clk), .pll_ref_o(pll_ref), .pll_fb_o(pll_fb));

  cfm_monitor #(.XO_PER_MS(4)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .in_clk_i(in_clk), .xo_clk_i(xo_clk), .pll_ref_i(pll_ref), .pll_fb_i(pll_fb),
    .input_loss_flag_o(loss), .drift_flag_o(drift), .lock_fail_flag_o(lock),
    .ref_osc_loss_flag_o(osc), .interrupt_out_n_o(int_n), .gpo_o(gpo), .switch_req_o(swr));

  // ====
  // Shared helpers.
  task wrap_up();
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge core_clk_i);
    while (ack !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        num_errors++;
        wrap_up();
      end
      @(posedge core_clk_i);
    end
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Waits for one watched output to reach a level.
  task wait_out(input int idx, input logic lvl, input int lim);
    int n;
    logic [12:0] o;
    n = 0;
    o = {osc, lock, loss, drift};
    while (o[idx] !== lvl)
    begin
      n++;
      if (n > lim)
      begin
        num_errors++;
        wrap_up();
      end
      @(posedge core_clk_i);
      #1;
      o = {osc, lock, loss, drift};
    end
  endtask

  // ====
  // Scenarios.
  task t_reset();
    chk({osc, int_n, gpo, swr, lock, drift, loss}, 32'h40000);
    wb(1'b0, `CFM_OFF_LOSS, 32'h0);
    chk(rv, 32'h00204);
    wb(1'b0, `CFM_OFF_PERIOD, 32'h0);
    chk(rv, 32'h10);
    wb(1'b0, `CFM_OFF_FD, 32'h0);
    chk(rv, 32'h0012050a);
    wb(1'b0, `CFM_OFF_WIN, 32'h0);
    chk(rv, 32'h400);
    wb(1'b0, `CFM_OFF_LL, 32'h0);
    chk(rv, 32'h04000067);
    wb(1'b0, 8'hfc, 32'h0);
    chk(rv, 32'h0);
  endtask

  task t_loss();
    wb(1'b1, `CFM_OFF_NEN, 32'h1ffff);
    @(posedge core_clk_i);
    in_run <= 4'he;
    wait_out(4, 1'b1, 400);
    @(posedge core_clk_i);
    #1;
    chk(swr, 4'h1);
    wb(1'b0, `CFM_OFF_STATUS, 32'h0);
    chk(rv, 32'h1);
    in_run <= 4'hf;
    repeat (40) @(posedge core_clk_i);
    chk(loss, 4'h1);
    wait_out(4, 1'b0, 2000);
    wb(1'b0, `CFM_OFF_STATUS, 32'h0);
    chk(rv, 32'h0);
    wb(1'b0, `CFM_OFF_NOTIFY, 32'h0);
    chk(rv, 32'h1);
    chk(int_n, 1'b1);
    wb(1'b1, `CFM_OFF_GPO0, 32'h0);
    wb(1'b1, `CFM_OFF_GPO1, 32'h80000002);
    @(posedge core_clk_i);
    #1;
    chk(gpo, 2'b01);
    wb(1'b1, `CFM_OFF_GPO1, 32'h80000003);
    @(posedge core_clk_i);
    #1;
    chk(gpo, 2'b11);
    wb(1'b1, `CFM_OFF_NOTIFY, 32'h1);
    wb(1'b0, `CFM_OFF_NOTIFY, 32'h0);
    chk(rv, 32'h0);
    chk(gpo, 2'b00);
  endtask

  task t_nen_off();
    wb(1'b1, `CFM_OFF_NEN, 32'h0);
    @(posedge core_clk_i);
    in_run <= 4'hd;
    wait_out(5, 1'b1, 400);
    wb(1'b0, `CFM_OFF_NOTIFY, 32'h0);
    chk(rv, 32'h0);
    in_run <= 4'hf;
    wait_out(5, 1'b0, 2000);
    wb(1'b1, `CFM_OFF_NEN, 32'h1ffff);
  endtask

  task t_drift();
    wb(1'b1, `CFM_OFF_CTRL, 32'h4);
    wb(1'b1, `CFM_OFF_WIN, 32'h10);
    repeat (40) @(posedge core_clk_i);
    wait_out(2, 1'b0, 600);
    @(posedge core_clk_i);
    in_run <= 4'hb;
    wait_out(2, 1'b1, 600);
    wb(1'b0, `CFM_OFF_STATUS, 32'h0);
    chk(rv[11:8], 4'h4);
    in_run <= 4'hf;
    wait_out(2, 1'b0, 6000);
  endtask

  task t_lock();
    wb(1'b1, `CFM_OFF_LL, 32'h00100067);
    @(posedge core_clk_i);
    fb_run <= 4'he;
    wait_out(8, 1'b1, 3000);
    chk(lock, 4'h1);
    fb_run <= 4'hf;
    wait_out(8, 1'b0, 6000);
    wb(1'b1, `CFM_OFF_NOTIFY, 32'h1ffff);
  endtask

  task t_osc();
    wb(1'b1, `CFM_OFF_IMASK, 32'h10000);
    @(posedge core_clk_i);
    xo_run <= 1'b0;
    wait_out(12, 1'b1, 300);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(int_n, 1'b0);
    wb(1'b1, `CFM_OFF_NOTIFY, 32'h10000);
    wb(1'b0, `CFM_OFF_NOTIFY, 32'h0);
    chk(rv[16], 1'b1);
    xo_run <= 1'b1;
    wait_out(12, 1'b0, 3000);
    wb(1'b0, `CFM_OFF_NOTIFY, 32'h0);
    chk(rv[16], 1'b1);
    wb(1'b1, `CFM_OFF_NOTIFY, 32'h10000);
    @(posedge core_clk_i);
    #1;
    chk(int_n, 1'b1);
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    t_reset();
    t_loss();
    t_nen_off();
    t_drift();
    t_lock();
    t_osc();
    wrap_up();
  end
endmodule

`default_nettype wire
